// ### rtl/bpsc_top.sv
`timescale 1ns/1ns
`default_nettype none
`include "bpsc_consts.svh"

module bpsc_top (
    input wire logic mclk_i,              // System clock, 20 MHz
    input wire logic rst_n_i,             // Function reset, async, active low
    input wire logic por_n_i,             // Power-on reset, async, active low
    input wire logic cfg_req_i,           // Configuration access request, one cycle
    input wire logic cfg_wr_i,            // 1 write, 0 read
    input wire logic [7:0] cfg_addr_i,    // Configuration byte offset, dword aligned
    input wire logic [3:0] cfg_be_i,      // Byte enables
    input wire logic [31:0] cfg_wdata_i,  // Write data
    output logic cfg_ack_o,               // Access complete, one cycle
    output logic cfg_hit_o,               // Access decoded to this register
    output logic [31:0] cfg_rdata_o,      // Read data
    input wire logic tgt_req_i,           // Transaction aimed at this function
    input wire logic tgt_cfg_i,           // That transaction is a configuration cycle
    output logic tgt_claim_o,             // Function claims the transaction
    input wire logic memreg_req_i,        // Cycle to memory mapped registers
    output logic memreg_claim_o,          // Memory mapped cycle claimed
    input wire logic irq_req_i,           // Internal interrupt request level
    output logic irq_o,                   // Interrupt to the system
    input wire logic dn_req_i,            // Downstream cycle offered to the bridge
    input wire logic dn_type0_cfg_i,      // Downstream cycle is type 0 configuration
    output logic dn_claim_o,              // Downstream cycle claimed
    output logic dn_fwd_o,                // Unclaimed cycle sent down the link
    input wire logic ur_return_i,         // Unsupported request came back up the link
    input wire logic mabort_clr_i,        // Host status clear of the master abort bit
    output logic mabort_sts_o,            // Host bridge status master abort flag
    output logic wake_sig_o,              // Wake event signal, never asserted
    output logic in_d0_o                  // Function is fully operational
);
    import bpsc_pkg::*;

    bpsc_state_type cur_r;
    bpsc_state_type cur_nxt;
    logic wake_en;
    logic sel;
    logic wr_go;
    logic d0;
    logic [31:0] rd_word;

    // Decode of this register's dword
    assign sel = (cfg_addr_i == `BPSC_PMCS_OFFSET);
    assign wr_go = cfg_req_i & cfg_wr_i & sel;
    assign d0 = (cur_r.pstate == BPSC_D0);

    // Wake enable sits in a store that only power-on clears
    bpsc_wake_keep u_keep (
        .mclk_i(mclk_i),
        .por_n_i(por_n_i),
        .wr_i(wr_go & cfg_be_i[`BPSC_WAKE_EN_LANE]),
        .wdata_i(cfg_wdata_i[`BPSC_WAKE_EN_BIT]),
        .wake_en_o(wake_en)
    );

    // Read word; everything not named below stays zero
    always_comb begin
        rd_word = 32'h00000000;
        rd_word[`BPSC_PSTATE_MSB:`BPSC_PSTATE_LSB] = cur_r.pstate;
        rd_word[`BPSC_WAKE_EN_BIT] = wake_en;
        rd_word[`BPSC_DATA_SEL_MSB:`BPSC_DATA_SEL_LSB] = `BPSC_DATA_SEL_VALUE;
        rd_word[`BPSC_DATA_SCALE_MSB:`BPSC_DATA_SCALE_LSB] = `BPSC_DATA_SCALE_VALUE;
        rd_word[`BPSC_WAKE_STS_BIT] = `BPSC_WAKE_STS_VALUE;
    end

    // Next state of the whole block
    always_comb begin
        cur_nxt = cur_r;

        // Every configuration access completes the cycle after it, in any state
        cur_nxt.cfg_ack = cfg_req_i;
        cur_nxt.cfg_hit = cfg_req_i & sel;
        if (cfg_req_i & !cfg_wr_i & sel) begin
            cur_nxt.cfg_rdata = rd_word;
        end else begin
            cur_nxt.cfg_rdata = 32'h00000000;
        end

        // Only the two supported codes move the state; others are dropped
        if (wr_go & cfg_be_i[`BPSC_PSTATE_LANE]) begin
            case (cfg_wdata_i[`BPSC_PSTATE_MSB:`BPSC_PSTATE_LSB])
                `BPSC_PSTATE_D0: begin
                    cur_nxt.pstate = BPSC_D0;
                end
                `BPSC_PSTATE_D3: begin
                    cur_nxt.pstate = BPSC_D3;
                end
                default: begin
                    cur_nxt.pstate = cur_r.pstate;
                end
            endcase
        end

        // Outside D0 only configuration cycles reach the function
        cur_nxt.tgt_claim = tgt_req_i & (d0 | tgt_cfg_i);
        cur_nxt.memreg_claim = memreg_req_i & d0;
        cur_nxt.irq = irq_req_i & d0;

        // Downstream routing: type 0 configuration always passes
        cur_nxt.dn_claim = dn_req_i & (d0 | dn_type0_cfg_i);
        cur_nxt.dn_fwd = dn_req_i & !d0 & !dn_type0_cfg_i;

        // Set beats clear so a returning request is never lost
        if (ur_return_i) begin
            cur_nxt.mabort_sts = 1'b1;
        end else if (mabort_clr_i) begin
            cur_nxt.mabort_sts = 1'b0;
        end

        // No wake signalling from any state, whatever the enable says
        cur_nxt.wake_sig = 1'b0;
        cur_nxt.in_d0 = (cur_nxt.pstate == BPSC_D0);
    end

    // Single register stage for all state
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cur_r.pstate <= BPSC_D0;
            cur_r.cfg_ack <= 1'b0;
            cur_r.cfg_hit <= 1'b0;
            cur_r.cfg_rdata <= 32'h00000000;
            cur_r.dn_claim <= 1'b0;
            cur_r.dn_fwd <= 1'b0;
            cur_r.tgt_claim <= 1'b0;
            cur_r.memreg_claim <= 1'b0;
            cur_r.irq <= 1'b0;
            cur_r.wake_sig <= 1'b0;
            cur_r.mabort_sts <= 1'b0;
            cur_r.in_d0 <= 1'b1;
        end else begin
            cur_r <= cur_nxt;
        end
    end

    // Outputs straight from the state register
    assign cfg_ack_o = cur_r.cfg_ack;
    assign cfg_hit_o = cur_r.cfg_hit;
    assign cfg_rdata_o = cur_r.cfg_rdata;
    assign tgt_claim_o = cur_r.tgt_claim;
    assign memreg_claim_o = cur_r.memreg_claim;
    assign irq_o = cur_r.irq;
    assign dn_claim_o = cur_r.dn_claim;
    assign dn_fwd_o = cur_r.dn_fwd;
    assign mabort_sts_o = cur_r.mabort_sts;
    assign wake_sig_o = cur_r.wake_sig;
    assign in_d0_o = cur_r.in_d0;

endmodule : bpsc_top
`default_nettype wire

// ### rtl/bpsc_consts.svh
`ifndef BPSC_CONSTS_SVH
`define BPSC_CONSTS_SVH

// Configuration offset of the power management control and status word
`define BPSC_PMCS_OFFSET 8'h84
// Field positions inside the control and status word
`define BPSC_PSTATE_MSB 1
`define BPSC_PSTATE_LSB 0
`define BPSC_WAKE_EN_BIT 8
`define BPSC_DATA_SEL_MSB 12
`define BPSC_DATA_SEL_LSB 9
`define BPSC_DATA_SCALE_MSB 14
`define BPSC_DATA_SCALE_LSB 13
`define BPSC_WAKE_STS_BIT 15
// Master abort position in the host bridge status word
`define BPSC_MABORT_STS_BIT 13
// Power state encodings, reset values and fixed field values
`define BPSC_PSTATE_D0 2'h0
`define BPSC_PSTATE_D3 2'h3
`define BPSC_PSTATE_RESET 2'h0
`define BPSC_WAKE_EN_RESET 1'h0
`define BPSC_WAKE_STS_VALUE 1'h0
`define BPSC_DATA_SCALE_VALUE 2'h0
`define BPSC_DATA_SEL_VALUE 4'h0
// Byte lanes holding the writable fields
`define BPSC_PSTATE_LANE 0
`define BPSC_WAKE_EN_LANE 1

`endif

// ### rtl/bpsc_pkg.sv
package bpsc_pkg;

    // Power state encodings; only the two supported codes exist
    typedef enum logic [1:0] {
        BPSC_D0 = 2'b00,
        BPSC_D3 = 2'b11
    } bpsc_pstate_type;

    // All state of the top module
    typedef struct packed {
        bpsc_pstate_type pstate;
        logic cfg_ack;
        logic cfg_hit;
        logic [31:0] cfg_rdata;
        logic dn_claim;
        logic dn_fwd;
        logic tgt_claim;
        logic memreg_claim;
        logic irq;
        logic wake_sig;
        logic mabort_sts;
        logic in_d0;
    } bpsc_state_type;

    // State of the reset-surviving store
    typedef struct packed {
        logic wake_en;
    } bpsc_keep_state_type;

endpackage : bpsc_pkg

// ### rtl/bpsc_wake_keep.sv
`timescale 1ns/1ns
`default_nettype none
`include "bpsc_consts.svh"

module bpsc_wake_keep (
    input wire logic mclk_i,   // System clock
    input wire logic por_n_i,  // Power-on reset only, active low
    input wire logic wr_i,     // Write strobe for the stored bit
    input wire logic wdata_i,  // Value to store
    output logic wake_en_o     // Stored wake-event enable
);
    import bpsc_pkg::*;

    bpsc_keep_state_type cur_r;
    bpsc_keep_state_type cur_nxt;

    // Store a new value only on a write; the ordinary reset never reaches here
    always_comb begin
        cur_nxt = cur_r;
        if (wr_i) begin
            cur_nxt.wake_en = wdata_i;
        end
    end

    // Cleared by power-on only, so the bit survives function resets
    always_ff @(posedge mclk_i or negedge por_n_i) begin
        if (!por_n_i) begin
            cur_r.wake_en <= `BPSC_WAKE_EN_RESET;
        end else begin
            cur_r <= cur_nxt;
        end
    end

    assign wake_en_o = cur_r.wake_en;

endmodule : bpsc_wake_keep
`default_nettype wire

// ### verif/bpsc_checker.sv
`timescale 1ns/1ns
`default_nettype none
module bpsc_checker (
    input wire logic mclk_i, rst_n_i, cfg_req_i, cfg_wr_i, // Clock, reset, strobe
    input wire logic [7:0] cfg_addr_i, // Offset
    input wire logic [3:0] cfg_be_i, // Lanes
    input wire logic [31:0] cfg_wdata_i, cfg_rdata_o, // Data
    input wire logic cfg_ack_o, tgt_req_i, tgt_cfg_i, tgt_claim_o, memreg_req_i, memreg_claim_o, // Gating
    input wire logic irq_o, dn_req_i, dn_type0_cfg_i, dn_claim_o, dn_fwd_o, // Downstream
    input wire logic ur_return_i, mabort_sts_o, wake_sig_o, in_d0_o // Status
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);
    // State field writes are recognised from the access and the code together, in the same cycle
    sequence s_pswr;
        cfg_req_i && cfg_wr_i && cfg_addr_i == 8'h84 && cfg_be_i[0];
    endsequence
    property p_bad; s_pswr ##0 (cfg_wdata_i[0] != cfg_wdata_i[1]) |=> $stable(in_d0_o); endproperty
    property p_d3; s_pswr ##0 (cfg_wdata_i[1:0] == 2'h3) |=> !in_d0_o; endproperty
    property p_ack; cfg_req_i |=> cfg_ack_o; endproperty
    property p_rsv; cfg_ack_o |-> cfg_rdata_o[31:9] == 23'h0 && cfg_rdata_o[7:2] == 6'h0; endproperty
    property p_dn; dn_req_i |=> dn_fwd_o != dn_claim_o && dn_claim_o == $past(in_d0_o || dn_type0_cfg_i); endproperty
    property p_tgt; tgt_req_i |=> tgt_claim_o == $past(in_d0_o || tgt_cfg_i); endproperty
    property p_memreg; memreg_req_i |=> memreg_claim_o == $past(in_d0_o); endproperty
    property p_irq; !in_d0_o |=> !irq_o; endproperty
    property p_ur; ur_return_i |=> mabort_sts_o; endproperty
    property p_wake; !wake_sig_o; endproperty
    a_bad: assert property (p_bad) else $error("bad state code changed state");
    a_d3: assert property (p_d3) else $error("state write to D3 not taken");
    a_ack: assert property (p_ack) else $error("config access not acknowledged");
    a_rsv: assert property (p_rsv) else $error("fixed bits not zero");
    a_dn: assert property (p_dn) else $error("downstream claim wrong");
    a_tgt: assert property (p_tgt) else $error("target claim wrong");
    a_memreg: assert property (p_memreg) else $error("register cycle claim wrong");
    a_irq: assert property (p_irq) else $error("interrupt outside D0");
    a_ur: assert property (p_ur) else $error("master abort not logged");
    a_wake: assert property (p_wake) else $error("wake signal raised");
endmodule : bpsc_checker
bind bpsc_top bpsc_checker i_chk (.mclk_i, .rst_n_i, .cfg_req_i, .cfg_wr_i, .cfg_addr_i, .cfg_be_i,
    .cfg_wdata_i, .cfg_rdata_o, .cfg_ack_o, .tgt_req_i, .tgt_cfg_i, .tgt_claim_o, .memreg_req_i,
    .memreg_claim_o, .irq_o, .dn_req_i, .dn_type0_cfg_i, .dn_claim_o, .dn_fwd_o, .ur_return_i,
    .mabort_sts_o, .wake_sig_o, .in_d0_o);
`default_nettype wire

// ### verif/bpsc_top_tb.sv
`timescale 1ns/1ns
`default_nettype none
module bpsc_top_tb;
    logic mclk_i = 0, rst_n_i = 0, por_n_i = 0, cfg_req_i = 0, cfg_wr_i = 0, tgt_req_i = 0, tgt_cfg_i = 0;
    logic memreg_req_i = 0, irq_req_i = 0, dn_req_i = 0, dn_type0_cfg_i = 0, ur_return_i = 0, mabort_clr_i = 0;
    logic [7:0] cfg_addr_i = 0;
    logic [3:0] cfg_be_i = 0;
    logic [31:0] cfg_wdata_i = 0, cfg_rdata_o;
    logic cfg_ack_o, cfg_hit_o, tgt_claim_o, memreg_claim_o, irq_o, dn_claim_o, dn_fwd_o;
    logic mabort_sts_o, wake_sig_o, in_d0_o;
    logic [1:0] exp_state = 0; // Expected state field
    logic we = 0; // Expected wake enable
    int mismatches = 0, n_tests = 0;
    bpsc_top i_dut (.*);
    always #25 mclk_i = ~mclk_i;
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        n_tests++;
        if (s !== e) begin
            mismatches++;
            $display("[FAIL] %0t seen %h expected %h", $time, s, e);
        end
    endtask : chk
    function automatic logic [31:0] word();
        return {23'h0, we, 6'h0, exp_state};
    endfunction : word
    // One access, then the model follows; codes 01 and 10 are dropped
    task automatic cfg(input logic w, input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
        logic hit;
        hit = a == 8'h84;
        @(posedge mclk_i);
        {cfg_req_i, cfg_wr_i, cfg_addr_i, cfg_be_i, cfg_wdata_i} <= {1'b1, w, a, be, d};
        @(posedge mclk_i);
        cfg_req_i <= 1'b0;
        #1;
        chk({cfg_ack_o, cfg_hit_o}, {1'b1, hit});
        chk(cfg_rdata_o, (hit && !w) ? word() : 32'h0);
        if (hit && w && be[0] && d[0] == d[1]) exp_state = d[1:0];
        if (hit && w && be[1]) we = d[8];
    endtask : cfg
    // Downstream, register and target requests at once; random qualifiers and interrupt request
    task automatic probe();
        logic [2:0] r;
        logic d0;
        r = 3'($urandom);
        d0 = exp_state == 2'h0;
        @(posedge mclk_i);
        {dn_req_i, memreg_req_i, tgt_req_i, dn_type0_cfg_i, tgt_cfg_i, irq_req_i} <= {3'h7, r};
        @(posedge mclk_i);
        {dn_req_i, memreg_req_i, tgt_req_i} <= 3'h0;
        #1;
        chk(in_d0_o, d0);
        chk({dn_claim_o, dn_fwd_o}, {d0 | r[2], !(d0 | r[2])});
        chk({memreg_claim_o, irq_o, wake_sig_o}, {d0, d0 & r[0], 1'b0});
        chk(tgt_claim_o, d0 | r[1]);
    endtask : probe
    task automatic summarize();
        if (mismatches == 0 && n_tests > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : summarize
    initial begin
        #100000;
        mismatches++;
        summarize();
    end
    initial begin
        void'($urandom(32'h87383b78));
        repeat (5) @(posedge mclk_i);
        {rst_n_i, por_n_i} <= 2'h3;
        cfg(0, 8'h84, 4'hf, 0);
        // Codes 3,2,1,0 twice, then random traffic with misses
        for (int i = 0; i < 60; i++) begin
            if (i < 8) cfg(1, 8'h84, 4'h1, 32'(3 - i % 4));
            else cfg(1'($urandom), $urandom % 3 ? 8'h84 : 8'($urandom), 4'($urandom), $urandom);
            cfg(0, 8'h84, 4'hf, 0);
            probe();
        end
        // Function reset keeps wake enable but returns to D0
        cfg(1, 8'h84, 4'h3, 32'hffff_ffff);
        @(posedge mclk_i);
        rst_n_i <= 0;
        repeat (2) @(posedge mclk_i);
        rst_n_i <= 1;
        exp_state = 0;
        cfg(0, 8'h84, 4'hf, 0);
        // Set beats a coincident clear; flag sticks until cleared
        @(posedge mclk_i);
        {ur_return_i, mabort_clr_i} <= 2'h3;
        @(posedge mclk_i);
        {ur_return_i, mabort_clr_i} <= 2'h0;
        #1 chk(mabort_sts_o, 1);
        @(posedge mclk_i);
        mabort_clr_i <= 1;
        #1 chk(mabort_sts_o, 1);
        @(posedge mclk_i);
        mabort_clr_i <= 0;
        #1 chk(mabort_sts_o, 0);
        summarize();
    end
endmodule : bpsc_top_tb
`default_nettype wire
